// ===== src/icl_calib_regs.sv
// Purpose: input calibration limit and default register bank
// Assumes: control port gives index, write strobe, read strobe
// Notes:   one measurement set is screened per request, both vertical windows at once
//          measured inputs must hold from request until done
//          the counter divider is fixed, so a wrap takes many minutes
//
// Operation
// [R1] vertical active below minimum uses default; minimum resets 32768
// [R2] vertical active above maximum uses default; maximum resets 64881
// [R3] no valid vertical set uses default active 63898
// [R4] vertical start below minimum uses default; minimum resets 1311
// [R5] vertical start above maximum uses default; maximum resets 32767
// [R6] no valid set or out of range start uses default 1638
// [R7] readable 8-bit counter ticks at oscillator over 786432
// [R8] pixel width fraction register, 16 bits, scaled by 65536
// [R9] line height fraction register, 16 bits, resets zero
// [R10] manual select uses manual horizontal active, resets 55706
// [R11] manual vertical active replaces measured value, resets 63898
// [R12] all vertical values are unsigned 16-bit fractions times 65536
// [R13] coarse counter wraps from 255 to zero and keeps running
`include "icl_regs_map.svh"
`timescale 1ns/1ps
`default_nettype none
module icl_calib_regs
	import icl_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       osc_ref,
	input  wire icl_addr_t  reg_addr,
	input  wire icl_frac_t  reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output var  icl_frac_t  reg_rdata,
	input  wire logic       manual_calibration_select,
	input  wire logic       meas_req,
	input  wire logic       meas_valid,
	input  wire icl_frac_t  meas_vertical_active,
	input  wire icl_frac_t  meas_vertical_start,
	input  wire icl_frac_t  meas_horizontal_active,
	output var  icl_frac_t  vertical_active_size,
	output var  icl_frac_t  vertical_start_position,
	output var  icl_frac_t  horizontal_active_size,
	output var  logic       result_done
);
	icl_frac_t  va_min_r, va_max_r, va_def_r;
	icl_frac_t  vs_min_r, vs_max_r, vs_def_r;
	icl_frac_t  pix_r, line_r, man_ha_r, man_va_r;
	logic [7:0] tick_r;
	logic [19:0] div_r;
	logic       osc_s1_r, osc_s2_r, osc_s3_r;
	logic       osc_rise;
	icl_state_t st_r;
	icl_frac_t  va_chk, vs_chk;
	icl_frac_t  rdata_nxt;
	logic       tick_fire, in_check;

	// one carrier and one screen per vertical quantity
	icl_limit_if lim_va ();
	icl_limit_if lim_vs ();

	icl_limit_check u_va (.lim(lim_va));
	icl_limit_check u_vs (.lim(lim_vs));

	// screen active size against its window
	// limits are inclusive: a value equal to a bound is kept
	assign lim_va.lo     = va_min_r;  // R1
	assign lim_va.hi     = va_max_r;  // R2
	assign lim_va.dflt   = va_def_r;  // R3
	assign lim_va.sample = meas_vertical_active;
	assign lim_va.valid  = meas_valid;
	assign va_chk        = lim_va.result;

	// screen start position against its window
	// start is screened in manual mode too, nothing replaces it
	assign lim_vs.lo     = vs_min_r;  // R4
	assign lim_vs.hi     = vs_max_r;  // R5
	assign lim_vs.dflt   = vs_def_r;  // R6
	assign lim_vs.sample = meas_vertical_start;
	assign lim_vs.valid  = meas_valid;
	assign vs_chk        = lim_vs.result;

	// index decode shared by every register write
	function automatic logic hit(input icl_addr_t a, input icl_addr_t o);
		hit = (a == o);
	endfunction : hit

	// smallest active size the screen keeps
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			va_min_r <= `ICL_RST_VA_MIN;  // R1
		end else if (reg_wr && hit(reg_addr, `ICL_OFF_VA_MIN)) begin
			va_min_r <= reg_wdata;  // R12
		end
	end

	// largest active size the screen keeps
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			va_max_r <= `ICL_RST_VA_MAX;  // R2
		end else if (reg_wr && hit(reg_addr, `ICL_OFF_VA_MAX)) begin
			va_max_r <= reg_wdata;  // R12
		end
	end

	// active size used when the screen rejects
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			va_def_r <= `ICL_RST_VA_DEF;  // R3
		end else if (reg_wr && hit(reg_addr, `ICL_OFF_VA_DEF)) begin
			va_def_r <= reg_wdata;  // R12
		end
	end

	// smallest start position the screen keeps
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vs_min_r <= `ICL_RST_VS_MIN;  // R4
		end else if (reg_wr && hit(reg_addr, `ICL_OFF_VS_MIN)) begin
			vs_min_r <= reg_wdata;  // R12
		end
	end

	// largest start position the screen keeps
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vs_max_r <= `ICL_RST_VS_MAX;  // R5
		end else if (reg_wr && hit(reg_addr, `ICL_OFF_VS_MAX)) begin
			vs_max_r <= reg_wdata;  // R12
		end
	end

	// start position used when the screen rejects
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vs_def_r <= `ICL_RST_VS_DEF;  // R6
		end else if (reg_wr && hit(reg_addr, `ICL_OFF_VS_DEF)) begin
			vs_def_r <= reg_wdata;  // R12
		end
	end

	// pixel width fraction; plain storage for the host
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pix_r <= `ICL_RST_PIX;
		end else if (reg_wr && hit(reg_addr, `ICL_OFF_PIX)) begin
			pix_r <= reg_wdata;  // R8
		end
	end

	// line height fraction; plain storage for the host
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			line_r <= `ICL_RST_LINE;  // R9
		end else if (reg_wr && hit(reg_addr, `ICL_OFF_LINE)) begin
			line_r <= reg_wdata;  // R9
		end
	end

	// manual horizontal active size
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			man_ha_r <= `ICL_RST_MAN_HA;  // R10
		end else if (reg_wr && hit(reg_addr, `ICL_OFF_MAN_HA)) begin
			man_ha_r <= reg_wdata;
		end
	end

	// manual vertical active size
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			man_va_r <= `ICL_RST_MAN_VA;  // R11
		end else if (reg_wr && hit(reg_addr, `ICL_OFF_MAN_VA)) begin
			man_va_r <= reg_wdata;
		end
	end

	// oscillator arrives from outside: two flops before any use
	// only the edge detector reads the third flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
		end else begin
			osc_s1_r <= osc_ref;
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
		end
	end
	assign osc_rise = osc_s2_r & ~osc_s3_r;

	// last oscillator edge of a divider period
	assign tick_fire = osc_rise && (div_r == `ICL_TICK_LAST);

	// divide oscillator edges; oscillator must stay below clk/2
	// a counter write leaves the divider phase alone
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= `ICL_DIV_ZERO;
		end else if (osc_rise) begin
			div_r <= tick_fire ? `ICL_DIV_ZERO
				: div_r + `ICL_DIV_ONE;  // R7
		end
	end

	// coarse counter; a write presets it, the tick still wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_r <= `ICL_RST_TICK;  // R7
		end else if (tick_fire) begin
			tick_r <= tick_r + 8'h01;  // R13
		end else if (reg_wr && hit(reg_addr, `ICL_OFF_TICK)) begin
			tick_r <= reg_wdata[7:0];
		end
	end

	// read selection; unmapped indices read zero
	always_comb begin
		rdata_nxt = `ICL_ZERO16;
		case (reg_addr)
			`ICL_OFF_VA_MIN: rdata_nxt = va_min_r;
			`ICL_OFF_VA_MAX: rdata_nxt = va_max_r;
			`ICL_OFF_VA_DEF: rdata_nxt = va_def_r;
			`ICL_OFF_VS_MIN: rdata_nxt = vs_min_r;
			`ICL_OFF_VS_MAX: rdata_nxt = vs_max_r;
			`ICL_OFF_VS_DEF: rdata_nxt = vs_def_r;
			`ICL_OFF_TICK:   rdata_nxt = {8'h00, tick_r};  // R7
			`ICL_OFF_PIX:    rdata_nxt = pix_r;            // R8
			`ICL_OFF_LINE:   rdata_nxt = line_r;           // R9
			`ICL_OFF_MAN_HA: rdata_nxt = man_ha_r;
			`ICL_OFF_MAN_VA: rdata_nxt = man_va_r;
			default:         rdata_nxt = `ICL_ZERO16;
		endcase
	end

	// read data register; it holds between reads
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= `ICL_ZERO16;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end
	end

	// request sequencer: one cycle to latch the screened values
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= ICL_IDLE;
		end else begin
			case (st_r)
				ICL_IDLE:  st_r <= meas_req ? ICL_CHECK : ICL_IDLE;
				ICL_CHECK: st_r <= ICL_DONE;
				ICL_DONE:  st_r <= ICL_IDLE;
				default:   st_r <= ICL_IDLE;
			endcase
		end
	end

	// the one state in which screened values are latched
	assign in_check = (st_r == ICL_CHECK);

	// active size result; manual mode bypasses the window
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vertical_active_size <= `ICL_RST_VA_DEF;  // R3
		end else if (in_check) begin
			if (manual_calibration_select) begin
				vertical_active_size <= man_va_r;  // R11
			end else begin
				vertical_active_size <= va_chk;    // R1
			end
		end
	end

	// horizontal result passes unscreened unless manual
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			horizontal_active_size <= `ICL_RST_MAN_HA;
		end else if (in_check) begin
			if (manual_calibration_select) begin
				horizontal_active_size <= man_ha_r;  // R10
			end else begin
				horizontal_active_size <= meas_horizontal_active;
			end
		end
	end

	// start result; measured inputs must hold until here
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vertical_start_position <= `ICL_RST_VS_DEF;
		end else if (in_check) begin
			vertical_start_position <= vs_chk;  // R6
		end
	end

	// done pulse lands with the results it announces
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			result_done <= 1'b0;
		end else begin
			result_done <= in_check;
		end
	end
endmodule : icl_calib_regs
`default_nettype wire

// ===== src/icl_regs_map.svh
// Purpose: offsets, reset values and timing counts of the calibration bank
// Assumes: byte-wide indices on the control port, 16-bit data
// Notes:   values are fractions of the total times 65536
`ifndef ICL_REGS_MAP_SVH
`define ICL_REGS_MAP_SVH
`define ICL_OFF_VA_MIN   8'h0b
`define ICL_OFF_VA_MAX   8'h0c
`define ICL_OFF_VA_DEF   8'h0d
`define ICL_OFF_VS_MIN   8'h0e
`define ICL_OFF_VS_MAX   8'h0f
`define ICL_OFF_VS_DEF   8'h10
`define ICL_OFF_TICK     8'h11
`define ICL_OFF_PIX      8'h12
`define ICL_OFF_LINE     8'h13
`define ICL_OFF_MAN_HA   8'h14
`define ICL_OFF_MAN_VA   8'h15
`define ICL_RST_VA_MIN   16'h8000
`define ICL_RST_VA_MAX   16'hfd71
`define ICL_RST_VA_DEF   16'hf99a
`define ICL_RST_VS_MIN   16'h051f
`define ICL_RST_VS_MAX   16'h7fff
`define ICL_RST_VS_DEF   16'h0666
`define ICL_RST_TICK     8'h00
`define ICL_RST_PIX      16'h0000
`define ICL_RST_LINE     16'h0000
`define ICL_RST_MAN_HA   16'hd99a
`define ICL_RST_MAN_VA   16'hf99a
`define ICL_TICK_DIV     20'hc0000
`define ICL_TICK_LAST    20'hbffff
`define ICL_DIV_ZERO     20'h00000
`define ICL_DIV_ONE      20'h00001
`define ICL_ZERO16       16'h0000
`endif

// ===== src/icl_pkg.sv
// Purpose: shared types of the calibration limit bank
// Assumes: nothing beyond the map header
// Notes:   types only; numbers live in the map header
package icl_pkg;
	typedef logic [15:0] icl_frac_t;
	typedef logic [7:0]  icl_addr_t;
	typedef enum logic [2:0] {
		ICL_IDLE  = 3'b001,
		ICL_CHECK = 3'b010,
		ICL_DONE  = 3'b100
	} icl_state_t;
endpackage : icl_pkg

// ===== src/icl_limit_if.sv
// Purpose: carries limit window and sample between top and checker
// Assumes: one clock domain
// Notes:   purely combinational carrier
`timescale 1ns/1ps
`default_nettype none
interface icl_limit_if;
	import icl_pkg::*;
	icl_frac_t lo;
	icl_frac_t hi;
	icl_frac_t dflt;
	icl_frac_t sample;
	logic      valid;
	icl_frac_t result;
	modport top (output lo, output hi, output dflt, output sample,
		output valid, input result);
	modport chk (input lo, input hi, input dflt, input sample,
		input valid, output result);
endinterface : icl_limit_if
`default_nettype wire

// ===== src/icl_limit_check.sv
// Purpose: choose measured value or default by the limit window
// Assumes: unsigned fractions, inclusive limits
// Notes:   combinational; the top registers its result
`timescale 1ns/1ps
`default_nettype none
module icl_limit_check (
	icl_limit_if.chk lim
);
	import icl_pkg::*;
	// out of window or no valid set: default wins
	always_comb begin
		if (!lim.valid || lim.sample < lim.lo || lim.sample > lim.hi) begin
			lim.result = lim.dflt;
		end else begin
			lim.result = lim.sample;
		end
	end
endmodule : icl_limit_check
`default_nettype wire

// ===== testbench/icl_regs_checker.sv
// Purpose: port-level checks of the calibration limit bank
// Assumes: one clock; limits do not change during a screening
// Notes:   counter reads may only step by one between reads
`timescale 1ns/1ps
`default_nettype none
module icl_regs_checker
	import icl_pkg::*;
(
	input wire logic      clk,
	input wire logic      rst_n,
	input wire icl_addr_t reg_addr,
	input wire icl_frac_t reg_wdata,
	input wire logic      reg_wr,
	input wire logic      reg_rd,
	input wire icl_frac_t reg_rdata,
	input wire logic      manual_calibration_select,
	input wire logic      meas_valid,
	input wire icl_frac_t meas_vertical_active,
	input wire icl_frac_t meas_vertical_start,
	input wire icl_frac_t vertical_active_size,
	input wire icl_frac_t vertical_start_position,
	input wire icl_frac_t horizontal_active_size,
	input wire logic      result_done
);
	localparam icl_frac_t RV [11:21] = '{16'h8000, 16'hfd71, 16'hf99a,
		16'h051f, 16'h7fff, 16'h0666, 16'h0000, 16'h0000, 16'h0000,
		16'hd99a, 16'hf99a};
	icl_frac_t sh [11:21];
	logic [7:0] tick_last;
	logic      tick_seen, rd_tick_d;
	wire logic dn = result_done && !manual_calibration_select;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// shadow of host writes, so limits may be moved by the bench
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) sh <= RV;
		else if (reg_wr && reg_addr inside {[8'h0b:8'h15]})
			sh[reg_addr] <= reg_wdata;
	end
	// last counter read; a write to the counter voids it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_tick_d <= 1'b0;
			tick_seen <= 1'b0;
			tick_last <= 8'h00;
		end else begin
			rd_tick_d <= reg_rd && !reg_wr && reg_addr == 8'h11;
			if (reg_wr && reg_addr == 8'h11) begin
				tick_seen <= 1'b0;
			end else if (rd_tick_d) begin
				tick_seen <= 1'b1;
				tick_last <= reg_rdata[7:0];
			end
		end
	end
	// screening results, two edges after the taken request
	va_low_a: assert property (dn && $past(meas_valid, 2) &&
		$past(meas_vertical_active, 2) < sh[11]
		|-> vertical_active_size == sh[13]) else $error("low active kept");
	va_high_a: assert property (dn && $past(meas_valid, 2) &&
		$past(meas_vertical_active, 2) > sh[12]
		|-> vertical_active_size == sh[13]) else $error("high active kept");
	va_novalid_a: assert property (dn && !$past(meas_valid, 2)
		|-> vertical_active_size == sh[13]) else $error("no default active");
	vs_low_a: assert property (result_done && $past(meas_valid, 2) &&
		$past(meas_vertical_start, 2) < sh[14]
		|-> vertical_start_position == sh[16]) else $error("low start kept");
	vs_high_a: assert property (result_done && $past(meas_valid, 2) &&
		$past(meas_vertical_start, 2) > sh[15]
		|-> vertical_start_position == sh[16]) else $error("high start kept");
	vs_novalid_a: assert property (result_done && !$past(meas_valid, 2)
		|-> vertical_start_position == sh[16]) else $error("no default start");
	man_horiz_a: assert property (result_done && manual_calibration_select
		|-> horizontal_active_size == sh[20]) else $error("manual horiz lost");
	man_vert_a: assert property (result_done && manual_calibration_select
		|-> vertical_active_size == sh[21]) else $error("manual vert lost");
	read_map_a: assert property ($past(reg_rd) && !$past(reg_wr) &&
		$past(reg_addr) inside {[8'h0b:8'h10], [8'h12:8'h15]}
		|-> reg_rdata == sh[$past(reg_addr)]) else $error("read data wrong");
	cover property (result_done && manual_calibration_select);
	cover property (dn && !$past(meas_valid, 2));
	tick_step_a: assert property (rd_tick_d && tick_seen
		|-> reg_rdata[15:8] == 8'h00 && (reg_rdata[7:0] == tick_last ||
		reg_rdata[7:0] == tick_last + 8'h01)) else $error("counter jumped");
	cover property (reg_rd && reg_addr == 8'h30);
	cover property (rd_tick_d && tick_seen);
endmodule : icl_regs_checker
`default_nettype wire

// ===== testbench/test_input_calib_limit_regs.sv
// Purpose: directed test of the calibration limit bank
// Assumes: screening answers two edges after the request
// Notes:   counter wrap is out of reach at this divider
`timescale 1ns/1ps
`default_nettype none
module test_input_calib_limit_regs;
	import icl_pkg::*;
	logic      clk = 0, rst_n = 0, osc = 0, wr = 0, rd = 0, man = 0;
	logic      req = 0, vld = 0, done;
	icl_addr_t addr = 8'h00;
	icl_frac_t wd = 16'h0000, mva = 16'h0000, mvs = 16'h0000;
	icl_frac_t mha = 16'h0000, rdat, va, vs, ha;
	int        err_total = 0, checks_done = 0;
	icl_frac_t rv [11:21] = '{16'h8000, 16'hfd71, 16'hf99a, 16'h051f,
		16'h7fff, 16'h0666, 16'h0000, 16'h0000, 16'h0000, 16'hd99a, 16'hf99a};
	icl_calib_regs icl_calib_regs_inst (.clk(clk), .rst_n(rst_n),
		.osc_ref(osc), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
		.reg_rd(rd), .reg_rdata(rdat), .manual_calibration_select(man),
		.meas_req(req), .meas_valid(vld), .meas_vertical_active(mva),
		.meas_vertical_start(mvs), .meas_horizontal_active(mha),
		.vertical_active_size(va), .vertical_start_position(vs),
		.horizontal_active_size(ha), .result_done(done));
	task automatic chk(input icl_frac_t got, input icl_frac_t exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr_reg(input icl_addr_t a, input icl_frac_t d);
		@(posedge clk) {addr, wd, wr} <= {a, d, 1'b1};
		@(posedge clk) wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input icl_addr_t a, input icl_frac_t e);
		@(posedge clk) {addr, rd} <= {a, 1'b1};
		@(posedge clk) rd <= 1'b0;
		#1 chk(rdat, e);
	endtask : rd_reg
	// horizontal input is the inverse of the active one, passed unscreened unless manual
	task automatic system_control_register(input logic v, input icl_frac_t a, s, ea, es);
		@(posedge clk) {req, vld, mva, mvs, mha} <= {1'b1, v, a, s, ~a};
		@(posedge clk) req <= 1'b0;
		@(posedge clk) #1 chk({15'h0000, done}, 16'h0001);
		chk(va, ea);
		chk(vs, es);
		chk(ha, man ? 16'h2222 : ~a);
	endtask : system_control_register
	task automatic close_out;
		$display("checks %0d, errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : close_out
	// clock, a slow reference oscillator, and a hang guard
	initial forever #50 clk = ~clk;
	initial forever begin
		repeat (7) @(posedge clk);
		osc <= ~osc;
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		close_out();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		// outputs show their reset values before any request
		#1 chk(va, rv[13]);
		chk(vs, rv[16]);
		chk(ha, rv[20]);
		chk({15'h0000, done}, 16'h0000);
		chk(rdat, 16'h0000);
		// reset values, unmapped index, pattern readback, restore
		for (int i = 11; i <= 21; i++) rd_reg(8'(i), rv[i]);
		rd_reg(8'h30, 16'h0000);
		for (int i = 11; i <= 21; i++) wr_reg(8'(i), 16'ha5c3 ^ 16'(i));
		for (int i = 11; i <= 21; i++) rd_reg(8'(i), (16'ha5c3 ^ 16'(i)) &
			(i == 17 ? 16'h00ff : 16'hffff));
		for (int i = 11; i <= 21; i++) wr_reg(8'(i), rv[i]);
		// two reads with no write between: counter may only step by one
		rd_reg(8'h11, 16'h0000);
		rd_reg(8'h11, 16'h0000);
		// edges of the window are accepted, one step out is not
		system_control_register(1, 16'h8000, 16'h051f, 16'h8000, 16'h051f);
		system_control_register(1, 16'h7fff, 16'h051e, 16'hf99a, 16'h0666);
		system_control_register(1, 16'hfd72, 16'h8000, 16'hf99a, 16'h0666);
		system_control_register(1, 16'hfd71, 16'h7fff, 16'hfd71, 16'h7fff);
		system_control_register(0, 16'h9000, 16'h1000, 16'hf99a, 16'h0666);
		wr_reg(8'h0b, 16'h9000);
		wr_reg(8'h0d, 16'h1234);
		system_control_register(1, 16'h8800, 16'h1000, 16'h1234, 16'h1000);
		@(posedge clk) man <= 1'b1;
		wr_reg(8'h14, 16'h2222);
		wr_reg(8'h15, 16'h3333);
		system_control_register(1, 16'h9000, 16'h0100, 16'h3333, 16'h0666);
		// reset in mid-run brings results and limits back
		@(posedge clk) rst_n <= 1'b0;
		@(posedge clk) #1 chk(va, rv[13]);
		chk(ha, rv[20]);
		@(posedge clk) rst_n <= 1'b1;
		rd_reg(8'h0d, rv[13]);
		rd_reg(8'h0b, rv[11]);
		close_out();
	end
endmodule : test_input_calib_limit_regs
bind icl_calib_regs icl_regs_checker icl_regs_checker_inst (.clk(clk),
	.rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.manual_calibration_select(manual_calibration_select),
	.meas_valid(meas_valid), .meas_vertical_active(meas_vertical_active),
	.meas_vertical_start(meas_vertical_start),
	.vertical_active_size(vertical_active_size),
	.vertical_start_position(vertical_start_position),
	.horizontal_active_size(horizontal_active_size),
	.result_done(result_done));
`default_nettype wire
